// >>> bench/apg_ctrl_checker.sv
`timescale 1ns/1ns
module apg_ctrl_checker
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       brownout_in,
    input wire logic [7:0] page_sel,
    input wire logic       soft_reset_pulse,
    input wire logic       dsp_power_on,
    input wire logic       power_fault_flag,
    input wire logic       brownout_cause,
    input wire logic [3:0] dac_gain_db,
    input wire logic [2:0] edge_rate_code,
    input wire logic [5:0] edge_time_ns
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write that lands on page zero
    wire logic pz = wr_en && page_sel == 8'h00 && !soft_reset_pulse;
    // Transition time in ns per edge code, code 0 rightmost
    wire logic [7:0][5:0] ns = {6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h19, 6'h1d, 6'h28, 6'h32};
    property p_pg; wr_en && !soft_reset_pulse && addr == 8'h00 |=> page_sel == $past(wdata); endproperty
    a_pg: assert property (p_pg) else $error("page not taken");
    property p_sr; pz && addr == 8'h01 && wdata[0] |=> soft_reset_pulse ##1 !soft_reset_pulse; endproperty
    a_sr: assert property (p_sr) else $error("reset pulse wrong");
    property p_bk; soft_reset_pulse |=> page_sel == 8'h00 && !dsp_power_on && dac_gain_db == 4'h0; endproperty
    a_bk: assert property (p_bk) else $error("bank not reset");
    property p_dsp; pz && addr == 8'h04 |=> power_fault_flag || dsp_power_on == $past(wdata[7]); endproperty
    a_dsp: assert property (p_dsp) else $error("dsp enable wrong");
    property p_gn; pz && addr == 8'h06 |=> dac_gain_db == $past(wdata[6:3]); endproperty
    a_gn: assert property (p_gn) else $error("gain wrong");
    property p_ed; edge_time_ns == ns[edge_rate_code]; endproperty
    a_ed: assert property (p_ed) else $error("edge time wrong");
    property p_ft; $rose(brownout_in) |-> ##[1:4] (power_fault_flag && brownout_cause); endproperty
    a_ft: assert property (p_ft) else $error("fault not flagged");
    property p_off; power_fault_flag |-> !dsp_power_on; endproperty
    a_off: assert property (p_off) else $error("powered in fault");
    property p_hd; power_fault_flag && !soft_reset_pulse && !(pz && addr == 8'h04 && !wdata[0]) |=> power_fault_flag; endproperty
    a_hd: assert property (p_hd) else $error("flag dropped");
endmodule
bind apg_ctrl apg_ctrl_checker chk_u (.*);

// >>> bench/apg_ctrl_tb.sv
`timescale 1ns/1ns
module apg_ctrl_tb;
    logic       clk, rst, wr_en, rd_en, brownout_in, clock_halt_in, cause_clear, rvalid;
    logic       soft_reset_pulse, power_fault_flag, brownout_cause, clock_halt_cause;
    logic [7:0] addr, wdata, rdata, page_sel, core, out;
    logic [8:0] pw, e;
    logic [3:0] dac_gain_db;
    logic [2:0] edge_rate_code;
    logic [5:0] edge_time_ns;
    int         num_errors = 0;
    int         comparisons = 0;
    logic [7:0] ofs [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h02};
    logic [5:0] ns [8] = '{6'h32, 6'h28, 6'h1d, 6'h19, 6'h0e, 6'h0d, 6'h0c, 6'h0b};

    apg_ctrl dut_u (
        .clk, .rst, .wr_en, .rd_en, .addr, .wdata, .brownout_in, .clock_halt_in, .cause_clear,
        .rdata, .rvalid, .page_sel, .soft_reset_pulse, .power_fault_flag, .brownout_cause,
        .clock_halt_cause, .dac_gain_db, .edge_rate_code, .edge_time_ns,
        .dsp_power_on(pw[8]), .pll_power_on(pw[7]), .n_divider_power_on(pw[6]),
        .dac_divider_power_on(pw[5]), .adc_divider_power_on(pw[4]), .class_d_output_power_on(pw[3]),
        .boost_power_on(pw[2]), .current_sense_power_on(pw[1]), .voltage_sense_power_on(pw[0]));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One write cycle; returns once its effect is visible
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    // One read cycle; bounded wait for rvalid, then data compare
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        int n;
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("rvalid", 9'(rvalid), 9'h001);
        if (rvalid !== 1'b1)
            conclude();
        chk("rdata", 9'(rdata), 9'(x));
    endtask

    // Bounded wait for the fault flag
    task automatic wait_flag();
        int n;
        n = 0;
        while (power_fault_flag !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("flag", 9'(power_fault_flag), 9'h001);
        if (power_fault_flag !== 1'b1)
            conclude();
    endtask

    // Main sequence
    initial begin
        {rst, wr_en, rd_en, brownout_in, clock_halt_in, cause_clear} = 6'h20;
        {addr, wdata} = 16'h0000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        chk("edge_ns", 9'(edge_time_ns), 9'h032);
        $display("test reset values done");
        // Other page hides the bank
        wr(8'h00, 8'h03);
        chk("page", 9'(page_sel), 9'h003);
        wr(8'h04, 8'hf8);
        rd(8'h04, 8'h00);
        wr(8'h00, 8'h00);
        chk("pwr", pw, 9'h000);
        $display("test page done");
        // Each enable alone
        for (int i = 0; i < 9; i++) begin
            e = 9'h001 << i;
            core = {e[8:4], 3'b000};
            out = {e[3], 1'b0, e[2], 3'b000, e[1:0]};
            wr(8'h04, core);
            wr(8'h05, out);
            chk("pwr", pw, e);
            rd(8'h04, core);
            rd(8'h05, out);
        end
        $display("test power done");
        for (int g = 0; g < 16; g++) begin
            wr(8'h06, {1'b0, 4'(g), 3'(g)});
            chk("gain", 9'(dac_gain_db), 9'(g[3:0]));
            chk("edge", 9'(edge_rate_code), 9'(g[2:0]));
            chk("edge_ns", 9'(edge_time_ns), 9'(ns[g % 8]));
        end
        rd(8'h06, 8'h7f);
        $display("test gain done");
        // Brownout, then clock halt
        wr(8'h05, 8'ha3);
        wr(8'h04, 8'hf8);
        for (int c = 0; c < 2; c++) begin
            @(posedge clk) {brownout_in, clock_halt_in} <= c ? 2'b01 : 2'b10;
            wait_flag();
            chk("cause", 9'({brownout_cause, clock_halt_cause}), c ? 9'h001 : 9'h002);
            chk("pwr", pw, 9'h000);
            rd(8'h04, 8'hf9);
            wr(8'h04, 8'hf8);
            chk("flag", 9'(power_fault_flag), 9'h001);
            chk("pwr", pw, 9'h000);
            @(posedge clk) {brownout_in, clock_halt_in} <= 2'b00;
            repeat (6) @(posedge clk);
            #1;
            chk("flag", 9'(power_fault_flag), 9'h001);
            wr(8'h04, 8'hf8);
            chk("pwr", pw, 9'h1ff);
            @(posedge clk) cause_clear <= 1'b1;
            @(posedge clk) cause_clear <= 1'b0;
            #1;
            chk("cause", 9'({brownout_cause, clock_halt_cause}), 9'h000);
        end
        $display("test fault done");
        wr(8'h01, 8'h00);
        rd(8'h04, 8'hf8);
        wr(8'h01, 8'h01);
        chk("swrst", 9'(soft_reset_pulse), 9'h001);
        @(posedge clk);
        #1;
        chk("swrst", 9'(soft_reset_pulse), 9'h000);
        chk("pwr", pw, 9'h000);
        chk("edge_ns", 9'(edge_time_ns), 9'h032);
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        $display("test soft reset done");
        conclude();
    end
endmodule

// >>> hdl/apg_ctrl.sv
`timescale 1ns/1ns
// Function
// - Eight-bit page selector, reset zero, steers which page later accesses reach.
// - Writing one to reset bit 0 starts software reset; bit self-clears.
// - Core power bit 7 powers the signal processor.
// - Core power bit 6 powers the phase-locked loop.
// - Core power bit 5 powers the N clock divider.
// - Core power bit 4 powers the DAC-side M divider.
// - Core power bit 3 powers the ADC-side M divider.
// - Core power bit 0 is set on brownout or clock halt.
// - A power fault automatically powers down several internal blocks.
// - The fault cause, brownout or halt, is recorded for the host.
// - Output power bit 7 powers the class-D output stage.
// - Output power bit 5 powers the boost converter.
// - Output power bits 1 and 0 power current and voltage sense ADCs.
// - Gain field bits 6..3 give gain in dB equal to code.
// - Edge field bits 2..0 select 50,40,29,25,14,13,12,11 ns.
`include "apg_params.svh"

module apg_ctrl
    import apg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       brownout_in,
    input  wire logic       clock_halt_in,
    input  wire logic       cause_clear,
    output logic      [7:0] rdata,
    output logic            rvalid,
    output logic      [7:0] page_sel,
    output logic            soft_reset_pulse,
    output logic            dsp_power_on,
    output logic            pll_power_on,
    output logic            n_divider_power_on,
    output logic            dac_divider_power_on,
    output logic            adc_divider_power_on,
    output logic            power_fault_flag,
    output logic            brownout_cause,
    output logic            clock_halt_cause,
    output logic            class_d_output_power_on,
    output logic            boost_power_on,
    output logic            current_sense_power_on,
    output logic            voltage_sense_power_on,
    output logic      [3:0] dac_gain_db,
    output logic      [2:0] edge_rate_code,
    output logic      [5:0] edge_time_ns
);

    apg_state_s st;
    apg_state_s next_st;
    logic [1:0] bo_sync;
    logic [1:0] ch_sync;

    // Transition time in ns for each edge-rate code
    function automatic logic [5:0] edge_ns_of(input logic [2:0] code);
        case (code)
            3'h0:    edge_ns_of = `APG_EDGE_NS_0;
            3'h1:    edge_ns_of = `APG_EDGE_NS_1;
            3'h2:    edge_ns_of = `APG_EDGE_NS_2;
            3'h3:    edge_ns_of = `APG_EDGE_NS_3;
            3'h4:    edge_ns_of = `APG_EDGE_NS_4;
            3'h5:    edge_ns_of = `APG_EDGE_NS_5;
            3'h6:    edge_ns_of = `APG_EDGE_NS_6;
            default: edge_ns_of = `APG_EDGE_NS_7;
        endcase
    endfunction

    // Access hits a page-zero register at the given offset
    function automatic logic hit(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] ofs);
        hit = (pg == `APG_PAGE_ZERO) && (a == ofs);
    endfunction

    // Fault inputs come from analog monitors: two-flop synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bo_sync <= 2'b00;
            ch_sync <= 2'b00;
        end else begin
            bo_sync <= {bo_sync[0], brownout_in};
            ch_sync <= {ch_sync[0], clock_halt_in};
        end
    end

    // Next-state logic
    always_comb begin
        logic fault_now;
        fault_now = bo_sync[1] | ch_sync[1];
        next_st = st;
        next_st.swrst_pulse = 1'b0;
        next_st.rvalid = 1'b0;
        if (st.swrst_pulse) begin
            // Software reset restores the whole bank
            next_st.page      = `APG_RST_PAGE;
            next_st.pwr_core  = `APG_RST_PWR_CORE;
            next_st.pwr_out   = `APG_RST_PWR_OUT;
            next_st.gain_slew = `APG_RST_GAIN_SLEW;
            next_st.cause     = '0;
        end else begin
            // Register writes; the page selector is reachable from any page
            if (wr_en) begin
                if (addr == `APG_OFS_PAGE)
                    next_st.page = wdata;
                if (hit(st.page, addr, `APG_OFS_RESET) && wdata[`APG_BIT_SWRST])
                    next_st.swrst_pulse = 1'b1;
                if (hit(st.page, addr, `APG_OFS_PWR_CORE))
                    next_st.pwr_core = wdata;
                if (hit(st.page, addr, `APG_OFS_PWR_OUT))
                    next_st.pwr_out = wdata;
                if (hit(st.page, addr, `APG_OFS_GAIN_SLEW))
                    next_st.gain_slew = wdata;
            end
            if (cause_clear)
                next_st.cause = '0;
            // Fault detection wins over a clearing write in the same cycle
            if (fault_now) begin
                next_st.pwr_core[`APG_BIT_FAULT] = 1'b1;
                if (bo_sync[1])
                    next_st.cause.brownout = 1'b1;
                if (ch_sync[1])
                    next_st.cause.clock_halt = 1'b1;
            end
            // Register reads
            if (rd_en) begin
                next_st.rvalid = 1'b1;
                if (addr == `APG_OFS_PAGE)
                    next_st.rdata = st.page;
                else if (hit(st.page, addr, `APG_OFS_RESET))
                    next_st.rdata = `APG_MASK_RESET_RD;
                else if (hit(st.page, addr, `APG_OFS_PWR_CORE))
                    next_st.rdata = st.pwr_core;
                else if (hit(st.page, addr, `APG_OFS_PWR_OUT))
                    next_st.rdata = st.pwr_out;
                else if (hit(st.page, addr, `APG_OFS_GAIN_SLEW))
                    next_st.rdata = st.gain_slew;
                else
                    next_st.rdata = 8'h00;
            end
        end
        // Enables follow register bits, forced off while the fault flag stands
        next_st.power.dsp     = next_st.pwr_core[`APG_BIT_DSP]  & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.pll     = next_st.pwr_core[`APG_BIT_PLL]  & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.n_div   = next_st.pwr_core[`APG_BIT_N_CLOCK_DIVIDER] & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.dac_div = next_st.pwr_core[`APG_BIT_DAC_M_DIVIDER] & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.adc_div = next_st.pwr_core[`APG_BIT_ADC_M_DIVIDER] & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.class_d = next_st.pwr_out[`APG_BIT_SPK]   & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.boost   = next_st.pwr_out[`APG_BIT_BOOST] & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.isns    = next_st.pwr_out[`APG_BIT_ISNS]  & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.power.vsns    = next_st.pwr_out[`APG_BIT_VSNS]  & ~next_st.pwr_core[`APG_BIT_FAULT];
        next_st.dac_gain_db   = next_st.gain_slew[`APG_GAIN_HI:`APG_GAIN_LO];
        next_st.edge_code     = next_st.gain_slew[`APG_EDGE_HI:`APG_EDGE_LO];
        next_st.edge_ns       = edge_ns_of(next_st.gain_slew[`APG_EDGE_HI:`APG_EDGE_LO]);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.edge_ns <= `APG_RST_EDGE_NS;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign rdata                   = st.rdata;
    assign rvalid                  = st.rvalid;
    assign page_sel                = st.page;
    assign soft_reset_pulse        = st.swrst_pulse;
    assign dsp_power_on            = st.power.dsp;
    assign pll_power_on            = st.power.pll;
    assign n_divider_power_on      = st.power.n_div;
    assign dac_divider_power_on    = st.power.dac_div;
    assign adc_divider_power_on    = st.power.adc_div;
    assign power_fault_flag        = st.pwr_core[`APG_BIT_FAULT];
    assign brownout_cause          = st.cause.brownout;
    assign clock_halt_cause        = st.cause.clock_halt;
    assign class_d_output_power_on = st.power.class_d;
    assign boost_power_on          = st.power.boost;
    assign current_sense_power_on  = st.power.isns;
    assign voltage_sense_power_on  = st.power.vsns;
    assign dac_gain_db             = st.dac_gain_db;
    assign edge_rate_code          = st.edge_code;
    assign edge_time_ns            = st.edge_ns;

endmodule

// >>> hdl/apg_params.svh
`ifndef APG_PARAMS_SVH
`define APG_PARAMS_SVH

// Register offsets on page zero
`define APG_OFS_PAGE        8'h00
`define APG_OFS_RESET       8'h01
`define APG_OFS_PWR_CORE    8'h04
`define APG_OFS_PWR_OUT     8'h05
`define APG_OFS_GAIN_SLEW   8'h06
`define APG_PAGE_ZERO       8'h00

// Reset values
`define APG_RST_PAGE        8'h00
`define APG_RST_PWR_CORE    8'h00
`define APG_RST_PWR_OUT     8'h00
`define APG_RST_GAIN_SLEW   8'h00
`define APG_RST_EDGE_NS     6'h32

// Field positions
`define APG_BIT_SWRST       0
`define APG_BIT_DSP         7
`define APG_BIT_PLL         6
`define APG_BIT_N_CLOCK_DIVIDER        5
`define APG_BIT_DAC_M_DIVIDER        4
`define APG_BIT_ADC_M_DIVIDER        3
`define APG_BIT_FAULT       0
`define APG_BIT_SPK         7
`define APG_BIT_BOOST       5
`define APG_BIT_ISNS        1
`define APG_BIT_VSNS        0
`define APG_GAIN_HI         6
`define APG_GAIN_LO         3
`define APG_EDGE_HI         2
`define APG_EDGE_LO         0

// Reserved masks: core bits 2..1 and out bits 6,4..2 are stored as written
`define APG_MASK_RESET_RD   8'h00

// Class-D transition times in ns per edge-rate code
`define APG_EDGE_NS_0       6'h32
`define APG_EDGE_NS_1       6'h28
`define APG_EDGE_NS_2       6'h1d
`define APG_EDGE_NS_3       6'h19
`define APG_EDGE_NS_4       6'h0e
`define APG_EDGE_NS_5       6'h0d
`define APG_EDGE_NS_6       6'h0c
`define APG_EDGE_NS_7       6'h0b

`endif

// >>> hdl/apg_pkg.sv
package apg_pkg;

    typedef struct packed {
        logic       dsp;
        logic       pll;
        logic       n_div;
        logic       dac_div;
        logic       adc_div;
        logic       class_d;
        logic       boost;
        logic       isns;
        logic       vsns;
    } apg_power_s;

    typedef struct packed {
        logic       brownout;
        logic       clock_halt;
    } apg_cause_s;

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] pwr_core;
        logic [7:0] pwr_out;
        logic [7:0] gain_slew;
        logic       swrst_pulse;
        apg_cause_s cause;
        logic [7:0] rdata;
        logic       rvalid;
        apg_power_s power;
        logic [3:0] dac_gain_db;
        logic [2:0] edge_code;
        logic [5:0] edge_ns;
    } apg_state_s;

endpackage
